// file: design/dcff_fifo.sv
// Deep FIFO with standard and fall-through timing and programmable flags
// Contract
// R01 - Timing mode is latched at reset from mode pin: low standard, high fall-through.
// R02 - Standard mode: every word, the first included, leaves only on read enable.
// R03 - Fall-through: first word into empty buffer shows after three read edges.
// R04 - Data is captured on each clock edge while write enable is low.
// R05 - Standard: empty flag rises after first write into empty buffer.
// R06 - Fall-through: output-ready falls after first write into empty buffer.
// R07 - Standard: almost-empty high at n+1 or more words, low at n or fewer.
// R08 - Standard: half-full low from depth/2+1 words, high below.
// R09 - Standard: almost-full low once count reaches depth minus m.
// R10 - Standard: full flag low at depth words; further writes ignored.
// R11 - First read from full clears full indication; other flags follow count.
// R12 - Reading last word signals empty; further reads blocked.
// R13 - Read enable ignored while empty; no pointer or output change.
// R14 - Standard: empty and full flags pass two register stages.
// R15 - Fall-through: output-ready passes three stages, input-ready two.
// R16 - Fall-through: almost-empty high at n+2 or more, low at n+1 or fewer.
// R17 - Fall-through: half-full low from depth/2+2 words.
// R18 - Fall-through: almost-full low once count reaches depth+1 minus m.
// R19 - Fall-through capacity is depth+1; input-ready high when reached.
// R20 - Load-select high at reset: serial loading, offsets preset to 3FF.
// R21 - Load-select low at reset: parallel loading, offsets preset to 07F.
// R22 - Offsets read back only by parallel read; the code also returns them on bus reads at ADDR_OFFSET.
// R23 - Offsets may be reprogrammed any time after reset.
// R24 - Serial load shifts one bit per edge, empty LSB first, full MSB last.
// R25 - Parallel load writes empty offset first, then full offset.
// R26 - Flags are derived from registered counts through register stages.
// R27 - Depth and all thresholds scale from one package constant.
module dcff_fifo (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [dcff_pkg::DW-1:0] data_in,
  input wire logic write_enable_n,
  input wire logic read_enable_n,
  input wire logic mode_select_serial_in,
  input wire logic load_select_n,
  input wire logic serial_enable_n,
  output logic [dcff_pkg::DW-1:0] data_out,
  output logic empty_flag_n,
  output logic full_flag_n,
  output logic output_ready_n,
  output logic input_ready_n,
  output logic almost_empty_flag_n,
  output logic almost_full_flag_n,
  output logic half_full_flag_n,
  input wire logic [dcff_pkg::BAW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic fall_through_mode_ff;
  logic [dcff_pkg::DW-1:0] mem_ff [dcff_pkg::DEPTH];
  logic [dcff_pkg::AW-1:0] wr_ptr_ff;
  logic [dcff_pkg::AW-1:0] rd_ptr_ff;
  logic [dcff_pkg::CW-1:0] mem_cnt_ff;
  logic [dcff_pkg::CW-1:0] nxt_mem_cnt;
  logic [dcff_pkg::CW-1:0] total_cnt;
  logic out_valid_ff;
  logic [dcff_pkg::DW-1:0] data_out_ff;
  logic output_ready_n_ff;
  logic almost_empty_flag_n_ff;
  logic almost_full_flag_n_ff;
  logic half_full_flag_n_ff;
  logic [31:0] avs_readdata_ff;
  logic avs_waitrequest_ff;
  logic [dcff_pkg::OW-1:0] empty_ofs;
  logic [dcff_pkg::OW-1:0] full_ofs;
  logic serial_mode;
  logic read_full_sel;
  logic mem_access;
  logic wr_mem;
  logic rd_req;
  logic rd_std;
  logic fall_ok;
  logic fall_through_mode_load;
  logic pop;
  logic par_read;
  logic bus_req;
  logic bus_done;
  logic bus_load;
  logic ef_in;
  logic ff_in;
  logic ir_in;
  logic fall_in;
  logic [dcff_pkg::CW-1:0] ae_thresh;
  logic [dcff_pkg::CW-1:0] af_thresh;
  logic [dcff_pkg::CW-1:0] hf_thresh;

  // ----------------------------------------------------------------
  // Mode strap
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    // R01 mode latch
    if (!rst_n)
    begin
      fall_through_mode_ff <= mode_select_serial_in;
    end
  end

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  assign mem_access = load_select_n;
  // R04 write capture
  // R10 full blocks writes
  assign wr_mem = mem_access && !write_enable_n && (mem_cnt_ff != dcff_pkg::CNT_DEPTH);
  assign rd_req = mem_access && !read_enable_n;
  // R02 explicit read
  // R13 ignore when empty
  assign rd_std = !fall_through_mode_ff && rd_req && (mem_cnt_ff != '0);
  // R03 fall-through load
  assign fall_through_mode_load = fall_through_mode_ff && (mem_cnt_ff != '0)
                     && (out_valid_ff ? rd_req : fall_ok);
  assign pop = rd_std || fall_through_mode_load;
  assign par_read = !load_select_n && write_enable_n && !read_enable_n && serial_enable_n;

  always_comb
  begin
    nxt_mem_cnt = mem_cnt_ff;
    if (wr_mem && !pop)
    begin
      nxt_mem_cnt = mem_cnt_ff + dcff_pkg::CNT_ONE;
    end
    else if (pop && !wr_mem)
    begin
      nxt_mem_cnt = mem_cnt_ff - dcff_pkg::CNT_ONE;
    end
  end

  // R19 output register adds one word
  assign total_cnt = mem_cnt_ff + {{(dcff_pkg::CW-1){1'b0}}, out_valid_ff};

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (wr_mem)
    begin
      mem_ff[wr_ptr_ff] <= data_in;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      mem_cnt_ff <= '0;
    end
    else
    begin
      if (wr_mem)
      begin
        wr_ptr_ff <= wr_ptr_ff + dcff_pkg::PTR_ONE;
      end
      if (pop)
      begin
        rd_ptr_ff <= rd_ptr_ff + dcff_pkg::PTR_ONE;
      end
      mem_cnt_ff <= nxt_mem_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Data output and output register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      data_out_ff <= '0;
      out_valid_ff <= 1'b0;
      output_ready_n_ff <= 1'b1;
    end
    else
    begin
      if (pop)
      begin
        data_out_ff <= mem_ff[rd_ptr_ff];
      end
      // R22 offset readback
      else if (par_read)
      begin
        data_out_ff <= dcff_pkg::DW'(read_full_sel ? full_ofs : empty_ofs);
      end
      // R12 last word empties
      if (fall_through_mode_load)
      begin
        out_valid_ff <= 1'b1;
      end
      else if (rd_req && fall_through_mode_ff)
      begin
        out_valid_ff <= 1'b0;
      end
      // R06 output ready
      // R15 third stage
      output_ready_n_ff <= !(fall_through_mode_ff && (fall_through_mode_load || (out_valid_ff && !rd_req)));
    end
  end

  // ----------------------------------------------------------------
  // Status flag stages
  // ----------------------------------------------------------------
  // R05 empty rises
  // R12 empty falls
  assign ef_in = fall_through_mode_ff || (mem_cnt_ff != '0);
  // R11 first read clears full
  assign ff_in = fall_through_mode_ff || (mem_cnt_ff != dcff_pkg::CNT_DEPTH);
  // R19 input ready
  assign ir_in = fall_through_mode_ff && (total_cnt == dcff_pkg::CNT_CAP_FALL_THROUGH_MODE);
  assign fall_in = (mem_cnt_ff != '0) && !out_valid_ff;

  // R14 two stages
  dcff_flag_pipe #(
    .STAGES(dcff_pkg::EF_STAGES),
    .RST_VAL(1'b0)
  ) u_ef_pipe (
    .clk(clk),
    .rst_n(rst_n),
    .flag_in(ef_in),
    .flag_out(empty_flag_n)
  );

  dcff_flag_pipe #(
    .STAGES(dcff_pkg::FF_STAGES),
    .RST_VAL(1'b1)
  ) u_ff_pipe (
    .clk(clk),
    .rst_n(rst_n),
    .flag_in(ff_in),
    .flag_out(full_flag_n)
  );

  // R15 two stages
  dcff_flag_pipe #(
    .STAGES(dcff_pkg::IR_STAGES),
    .RST_VAL(1'b0)
  ) u_ir_pipe (
    .clk(clk),
    .rst_n(rst_n),
    .flag_in(ir_in),
    .flag_out(input_ready_n)
  );

  // R26 registered fall-through
  dcff_flag_pipe #(
    .STAGES(dcff_pkg::OR_PRE_STAGES),
    .RST_VAL(1'b0)
  ) u_or_pipe (
    .clk(clk),
    .rst_n(rst_n),
    .flag_in(fall_in),
    .flag_out(fall_ok)
  );

  // ----------------------------------------------------------------
  // Programmable and half flags
  // ----------------------------------------------------------------
  // R07 standard empty threshold
  // R16 fall-through empty threshold
  assign ae_thresh = dcff_pkg::CW'(empty_ofs)
                     + (fall_through_mode_ff ? dcff_pkg::CNT_TWO : dcff_pkg::CNT_ONE);
  // R09 standard full threshold
  // R18 fall-through full threshold
  assign af_thresh = (fall_through_mode_ff ? dcff_pkg::CNT_CAP_FALL_THROUGH_MODE : dcff_pkg::CNT_DEPTH)
                     - dcff_pkg::CW'(full_ofs);
  // R08 standard half
  // R17 fall-through half
  // R27 depth scaling
  assign hf_thresh = fall_through_mode_ff ? dcff_pkg::CNT_HALF_FALL_THROUGH_MODE : dcff_pkg::CNT_HALF_STD;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      almost_empty_flag_n_ff <= 1'b0;
      almost_full_flag_n_ff <= 1'b1;
      half_full_flag_n_ff <= 1'b1;
    end
    else
    begin
      almost_empty_flag_n_ff <= (total_cnt >= ae_thresh);
      almost_full_flag_n_ff <= (total_cnt < af_thresh);
      half_full_flag_n_ff <= (total_cnt < hf_thresh);
    end
  end

  // ----------------------------------------------------------------
  // Offset registers
  // ----------------------------------------------------------------
  dcff_offsets u_offsets (
    .clk(clk),
    .rst_n(rst_n),
    .load_select_n(load_select_n),
    .serial_enable_n(serial_enable_n),
    .write_enable_n(write_enable_n),
    .read_enable_n(read_enable_n),
    .serial_in(mode_select_serial_in),
    .data_in(data_in),
    .bus_load(bus_load),
    .bus_empty_ofs(avs_writedata[dcff_pkg::OW-1:0]),
    .bus_full_ofs(avs_writedata[dcff_pkg::OFS_FULL_LSB +: dcff_pkg::OW]),
    .empty_ofs(empty_ofs),
    .full_ofs(full_ofs),
    .serial_mode(serial_mode),
    .read_full_sel(read_full_sel)
  );

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  assign bus_req = avs_read || avs_write;
  assign bus_done = bus_req && !avs_waitrequest_ff;
  // R23 bus reprogram
  assign bus_load = bus_done && avs_write && (avs_address == dcff_pkg::ADDR_OFFSET);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      avs_waitrequest_ff <= 1'b1;
      avs_readdata_ff <= '0;
    end
    else if (bus_req && avs_waitrequest_ff)
    begin
      avs_waitrequest_ff <= 1'b0;
      avs_readdata_ff <= '0;
      if (avs_read)
      begin
        unique case (avs_address)
          dcff_pkg::ADDR_STATUS:
          begin
            avs_readdata_ff[dcff_pkg::ST_FALL_THROUGH_MODE] <= fall_through_mode_ff;
            avs_readdata_ff[dcff_pkg::ST_SERIAL] <= serial_mode;
            avs_readdata_ff[dcff_pkg::ST_EMPTY] <= (total_cnt == '0);
            avs_readdata_ff[dcff_pkg::ST_FULL] <= (mem_cnt_ff == dcff_pkg::CNT_DEPTH);
          end
          dcff_pkg::ADDR_OFFSET:
          begin
            avs_readdata_ff[dcff_pkg::OW-1:0] <= empty_ofs;
            avs_readdata_ff[dcff_pkg::OFS_FULL_LSB +: dcff_pkg::OW] <= full_ofs;
          end
          dcff_pkg::ADDR_COUNT:
          begin
            avs_readdata_ff[dcff_pkg::CW-1:0] <= total_cnt;
          end
          default:
          begin
            avs_readdata_ff <= '0;
          end
        endcase
      end
    end
    else
    begin
      avs_waitrequest_ff <= 1'b1;
    end
  end

  assign data_out = data_out_ff;
  assign output_ready_n = output_ready_n_ff;
  assign almost_empty_flag_n = almost_empty_flag_n_ff;
  assign almost_full_flag_n = almost_full_flag_n_ff;
  assign half_full_flag_n = half_full_flag_n_ff;
  assign avs_readdata = avs_readdata_ff;
  assign avs_waitrequest = avs_waitrequest_ff;
endmodule : dcff_fifo

// file: design/dcff_pkg.sv
// Constants shared by the fall-through FIFO design files
package dcff_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int DEPTH = 8192;
  localparam int DW = 18;
  localparam int AW = 13;
  localparam int CW = 15;
  localparam int OW = 13;
  localparam logic [CW-1:0] CNT_ONE = CW'(1);
  localparam logic [CW-1:0] CNT_TWO = CW'(2);
  localparam logic [CW-1:0] CNT_DEPTH = CW'(DEPTH);
  localparam logic [CW-1:0] CNT_CAP_FALL_THROUGH_MODE = CW'(DEPTH + 1);
  localparam logic [CW-1:0] CNT_HALF_STD = CW'(DEPTH / 2 + 1);
  localparam logic [CW-1:0] CNT_HALF_FALL_THROUGH_MODE = CW'(DEPTH / 2 + 2);
  localparam logic [AW-1:0] PTR_ONE = AW'(1);
  // ----------------------------------------------------------------
  // Offsets
  // ----------------------------------------------------------------
  localparam logic [OW-1:0] OFS_SERIAL_DEF = 13'h03FF;
  localparam logic [OW-1:0] OFS_PARALLEL_DEF = 13'h007F;
  localparam int SER_BITS = 2 * OW;
  localparam int SW = 5;
  localparam logic [SW-1:0] SER_LAST = SW'(SER_BITS - 1);
  localparam logic [SW-1:0] SER_ONE = SW'(1);
  // ----------------------------------------------------------------
  // Flag register stages
  // ----------------------------------------------------------------
  localparam int EF_STAGES = 2;
  localparam int FF_STAGES = 2;
  localparam int IR_STAGES = 2;
  localparam int OR_PRE_STAGES = 2;
  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int BAW = 4;
  localparam logic [BAW-1:0] ADDR_STATUS = 4'h0;
  localparam logic [BAW-1:0] ADDR_OFFSET = 4'h4;
  localparam logic [BAW-1:0] ADDR_COUNT = 4'h8;
  localparam int ST_FALL_THROUGH_MODE = 0;
  localparam int ST_SERIAL = 1;
  localparam int ST_EMPTY = 2;
  localparam int ST_FULL = 3;
  localparam int OFS_FULL_LSB = 16;
endpackage : dcff_pkg

// file: design/dcff_flag_pipe.sv
// Register chain that delays one flag by a fixed number of stages
module dcff_flag_pipe #(
  parameter int STAGES = 2,
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flag_in,
  output logic flag_out
);
  logic [STAGES-1:0] stage_ff;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stage_ff <= {STAGES{RST_VAL}};
    end
    else
    begin
      stage_ff <= {stage_ff[STAGES-2:0], flag_in};
    end
  end

  assign flag_out = stage_ff[STAGES-1];
endmodule : dcff_flag_pipe

// file: design/dcff_offsets.sv
// Empty and full offset registers with serial, parallel and bus loading
module dcff_offsets (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load_select_n,
  input wire logic serial_enable_n,
  input wire logic write_enable_n,
  input wire logic read_enable_n,
  input wire logic serial_in,
  input wire logic [dcff_pkg::DW-1:0] data_in,
  input wire logic bus_load,
  input wire logic [dcff_pkg::OW-1:0] bus_empty_ofs,
  input wire logic [dcff_pkg::OW-1:0] bus_full_ofs,
  output logic [dcff_pkg::OW-1:0] empty_ofs,
  output logic [dcff_pkg::OW-1:0] full_ofs,
  output logic serial_mode,
  output logic read_full_sel
);
  logic serial_mode_ff;
  logic [dcff_pkg::OW-1:0] empty_ofs_ff;
  logic [dcff_pkg::OW-1:0] full_ofs_ff;
  logic [dcff_pkg::SW-1:0] ser_idx_ff;
  logic wr_full_sel_ff;
  logic rd_full_sel_ff;
  logic ser_shift;
  logic par_write;
  logic par_read;

  // R24 serial shift
  assign ser_shift = serial_mode_ff && !load_select_n && !serial_enable_n
                     && write_enable_n && read_enable_n;
  // R25 parallel write
  assign par_write = !serial_mode_ff && !load_select_n && !write_enable_n
                     && read_enable_n && serial_enable_n;
  // R22 parallel readback
  assign par_read = !load_select_n && write_enable_n && !read_enable_n
                    && serial_enable_n;

  // ----------------------------------------------------------------
  // Offset storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      // R20 serial default
      // R21 parallel default
      serial_mode_ff <= load_select_n;
      empty_ofs_ff <= load_select_n ? dcff_pkg::OFS_SERIAL_DEF : dcff_pkg::OFS_PARALLEL_DEF;
      full_ofs_ff <= load_select_n ? dcff_pkg::OFS_SERIAL_DEF : dcff_pkg::OFS_PARALLEL_DEF;
    end
    // R23 reprogram anytime
    else if (bus_load)
    begin
      empty_ofs_ff <= bus_empty_ofs;
      full_ofs_ff <= bus_full_ofs;
    end
    else if (ser_shift)
    begin
      if (ser_idx_ff < dcff_pkg::SW'(dcff_pkg::OW))
      begin
        empty_ofs_ff[ser_idx_ff[3:0]] <= serial_in;
      end
      else
      begin
        full_ofs_ff[4'(ser_idx_ff - dcff_pkg::SW'(dcff_pkg::OW))] <= serial_in;
      end
    end
    else if (par_write)
    begin
      if (wr_full_sel_ff)
      begin
        full_ofs_ff <= data_in[dcff_pkg::OW-1:0];
      end
      else
      begin
        empty_ofs_ff <= data_in[dcff_pkg::OW-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequence pointers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ser_idx_ff <= '0;
      wr_full_sel_ff <= 1'b0;
      rd_full_sel_ff <= 1'b0;
    end
    else
    begin
      if (ser_shift)
      begin
        ser_idx_ff <= (ser_idx_ff == dcff_pkg::SER_LAST) ? '0 : ser_idx_ff + dcff_pkg::SER_ONE;
      end
      if (par_write)
      begin
        wr_full_sel_ff <= !wr_full_sel_ff;
      end
      if (par_read)
      begin
        rd_full_sel_ff <= !rd_full_sel_ff;
      end
    end
  end

  assign empty_ofs = empty_ofs_ff;
  assign full_ofs = full_ofs_ff;
  assign serial_mode = serial_mode_ff;
  assign read_full_sel = rd_full_sel_ff;
endmodule : dcff_offsets

// file: tb/dcff_fifo_sva.sv
// Port checker for the FIFO flags and bus handshake
module dcff_fifo_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic write_enable_n,
  input wire logic read_enable_n,
  input wire logic mode_select_serial_in,
  input wire logic load_select_n,
  input wire logic [dcff_pkg::DW-1:0] data_out,
  input wire logic empty_flag_n,
  input wire logic full_flag_n,
  input wire logic output_ready_n,
  input wire logic input_ready_n,
  input wire logic half_full_flag_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ns;
  logic fw_ff;
  logic [dcff_pkg::CW-1:0] cnt_ff;
  logic wr;
  logic rd;
  assign wr = load_select_n && !write_enable_n &&
    cnt_ff < (fw_ff ? dcff_pkg::CNT_CAP_FALL_THROUGH_MODE : dcff_pkg::CNT_DEPTH);
  assign rd = load_select_n && !read_enable_n && cnt_ff != 0 && !fw_ff;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      fw_ff <= mode_select_serial_in;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cnt_ff <= '0;
    else
      cnt_ff <= cnt_ff + 15'(wr) - 15'(rd);
  end
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  chk_empty_high: assert property ((!fw_ff && cnt_ff != 0) [*4] |-> empty_flag_n)
    else $error("empty flag low with words stored");
  chk_empty_low: assert property ((!fw_ff && cnt_ff == 0) [*4] |-> !empty_flag_n)
    else $error("empty flag high with no words");
  chk_half_full: assert property ((!fw_ff && cnt_ff >= dcff_pkg::CNT_HALF_STD) [*4]
    |-> !half_full_flag_n)
    else $error("half full flag high above half");
  chk_full_low: assert property ((!fw_ff && cnt_ff == dcff_pkg::CNT_DEPTH) [*4]
    |-> !full_flag_n)
    else $error("full flag high at full depth");
  chk_idle_read: assert property (!fw_ff && cnt_ff == 0 && load_select_n && !read_enable_n
    |=> $stable(data_out))
    else $error("read while empty changed output");
  chk_fall_through_mode_fall: assert property (fw_ff && cnt_ff == 0 && wr
    |=> output_ready_n [*3] ##1 !output_ready_n)
    else $error("first word not shown on third edge");
  chk_fall_through_mode_cap: assert property ((fw_ff && cnt_ff == dcff_pkg::CNT_CAP_FALL_THROUGH_MODE) [*4]
    |-> input_ready_n)
    else $error("input ready not raised at capacity");
  chk_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  cover property (!fw_ff && cnt_ff == dcff_pkg::CNT_DEPTH);
  cover property (fw_ff && cnt_ff == dcff_pkg::CNT_CAP_FALL_THROUGH_MODE);
  cover property (avs_read && !avs_waitrequest);
endmodule : dcff_fifo_sva

bind dcff_fifo dcff_fifo_sva chk_u (.*);

// file: tb/dcff_port_model.sv
// Writer and reader model on the FIFO data side
module dcff_port_model (
  input wire logic clk,
  input wire logic wr_go,
  input wire logic rd_go,
  input wire logic [dcff_pkg::DW-1:0] word,
  output logic write_enable_n,
  output logic read_enable_n,
  output logic [dcff_pkg::DW-1:0] data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    write_enable_n = 1'b1;
    read_enable_n = 1'b1;
    data_in = '0;
  end
  always @(posedge clk)
  begin
    write_enable_n <= !wr_go;
    read_enable_n <= !rd_go;
    data_in <= wr_go ? word : ~data_in;
  end
endmodule : dcff_port_model

// file: tb/dcff_fifo_bench.sv
// Self-checking bench for the FIFO in both timing modes
module dcff_fifo_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mode_select_serial_in = 1'b0;
  logic load_select_n = 1'b0;
  logic serial_enable_n = 1'b1;
  logic [dcff_pkg::BAW-1:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic write_enable_n, read_enable_n;
  logic [dcff_pkg::DW-1:0] data_in, data_out;
  logic empty_flag_n, full_flag_n, output_ready_n, input_ready_n;
  logic almost_empty_flag_n, almost_full_flag_n, half_full_flag_n;
  logic [31:0] avs_readdata, r;
  logic avs_waitrequest;
  logic wr_go = 1'b0;
  logic rd_go = 1'b0;
  logic pend = 1'b0;
  logic [dcff_pkg::DW-1:0] word = '0;
  logic [dcff_pkg::DW-1:0] seed = 18'h0001A;
  logic [dcff_pkg::DW-1:0] exp_w = '0;
  logic [dcff_pkg::DW-1:0] q[$];
  int mismatches = 0;
  int n_tests = 0;
  int fw, n, m, ms;
  int ts[$];

  dcff_fifo dut_u (.*);
  dcff_port_model pm_u (
    .clk(clk),
    .wr_go(wr_go),
    .rd_go(rd_go),
    .word(word),
    .write_enable_n(write_enable_n),
    .read_enable_n(read_enable_n),
    .data_in(data_in)
  );

  initial
  begin
    forever #5 clk = ~clk;
  end

  task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  function automatic logic [dcff_pkg::DW-1:0] lfsr(logic [dcff_pkg::DW-1:0] v);
    return {v[16:0], v[17] ^ v[10]};
  endfunction : lfsr

  // Reference model: word queue and read data
  always @(posedge clk)
  begin
    ms = q.size();
    if (pend)
      check("data", data_out, exp_w);
    pend = 1'b0;
    if (rst_n && load_select_n)
    begin
      if (!read_enable_n && ms > 0 && fw == 0)
      begin
        exp_w = q.pop_front();
        pend = 1'b1;
      end
      if (!write_enable_n && ms < dcff_pkg::DEPTH + fw)
        q.push_back(data_in);
    end
  end

  task automatic rst(int md, int ld);
    rst_n <= 1'b0;
    mode_select_serial_in <= md[0];
    load_select_n <= ld[0];
    fw = md;
    n = ld ? 1023 : 127;
    m = n;
    q.delete();
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    mode_select_serial_in <= 1'b0;
    load_select_n <= 1'b1;
  endtask : rst

  task automatic put(int j);
    repeat (j)
    begin
      seed = lfsr(seed);
      wr_go <= 1'b1;
      word <= seed;
      @(posedge clk);
    end
    wr_go <= 1'b0;
  endtask : put

  task automatic take(int j);
    rd_go <= 1'b1;
    repeat (j) @(posedge clk);
    rd_go <= 1'b0;
  endtask : take

  task automatic flags();
    int s;
    int d;
    repeat (5) @(posedge clk);
    s = q.size();
    d = dcff_pkg::DEPTH + fw;
    check("half", half_full_flag_n, s < d / 2 + 1 + fw);
    check("almost empty", almost_empty_flag_n, s > n + fw);
    check("almost full", almost_full_flag_n, s < d - m);
    check("empty", fw ? output_ready_n : empty_flag_n, fw ? s == 0 : s != 0);
    check("full", fw ? input_ready_n : full_flag_n, fw ? s == d : s != d);
  endtask : flags

  task automatic sweep();
    foreach (ts[i])
    begin
      put(ts[i] - q.size());
      flags();
    end
  endtask : sweep

  task automatic bus(logic w, logic [dcff_pkg::BAW-1:0] a, logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do
    begin
      @(posedge clk);
    end
    while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (60000) @(posedge clk);
    mismatches++;
    finish_test();
  end

  initial
  begin
    rst(0, 0);
    bus(1'b0, dcff_pkg::ADDR_STATUS, 32'h0);
    check("status", r, 32'h4);
    bus(1'b0, dcff_pkg::ADDR_OFFSET, 32'h0);
    check("offset", r, 32'h007F007F);
    bus(1'b0, 4'hC, 32'h0);
    check("unmapped", r, 32'h0);
    take(2);
    put(1);
    flags();
    check("no fall", data_out, 32'h0);
    ts = '{127, 128, 4096, 4097, 8064, 8065, 8192, 8193};
    sweep();
    take(1);
    flags();
    take(q.size() + 1);
    flags();
    check("idle", data_out, exp_w);
    bus(1'b1, dcff_pkg::ADDR_OFFSET, 32'h00030002);
    bus(1'b0, dcff_pkg::ADDR_OFFSET, 32'h0);
    check("bus offset", r, 32'h00030002);
    load_select_n <= 1'b0;
    wr_go <= 1'b1;
    word <= 18'h5;
    @(posedge clk);
    word <= 18'h9;
    @(posedge clk);
    wr_go <= 1'b0;
    repeat (2) @(posedge clk);
    load_select_n <= 1'b1;
    n = 5;
    m = 9;
    bus(1'b0, dcff_pkg::ADDR_OFFSET, 32'h0);
    check("pin offset", r, 32'h00090005);
    ts = '{5, 6};
    sweep();
    rst(1, 1);
    bus(1'b0, dcff_pkg::ADDR_STATUS, 32'h0);
    check("status", r, 32'h7);
    bus(1'b0, dcff_pkg::ADDR_OFFSET, 32'h0);
    check("offset", r, 32'h03FF03FF);
    put(1);
    flags();
    check("fall", data_out, q[0]);
    ts = '{1024, 1025, 4097, 4098, 7169, 7170, 8193, 8194};
    sweep();
    bus(1'b0, dcff_pkg::ADDR_COUNT, 32'h0);
    check("count", r, q.size());
    // serial load of empty 5 and full 9
    load_select_n <= 1'b0;
    serial_enable_n <= 1'b0;
    for (int i = 0; i < 26; i++)
    begin
      mode_select_serial_in <= 1'(26'h0012005 >> i);
      @(posedge clk);
    end
    serial_enable_n <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      rd_go <= 1'b1;
      @(posedge clk);
      rd_go <= 1'b0;
      repeat (2) @(posedge clk);
      check("readback", data_out, i ? 32'h9 : 32'h5);
    end
    finish_test();
  end
endmodule : dcff_fifo_bench
